// [verification/pin_source_model.sv]
`timescale 1ns/1ps
module pin_source_model (
    input wire logic pclk,
    output logic timer_input_pin,
    output logic serial_receive_pin
);
    // Receive line idles high, as a recessive bus would
    initial begin
        timer_input_pin = 1'b0;
        serial_receive_pin = 1'b1;
    end
    // Settle long enough that the idle change is not taken for an edge
    task automatic set_idle(input logic lin, input logic lvl);
        @(posedge pclk);
        if (lin) serial_receive_pin <= lvl;
        else timer_input_pin <= lvl;
        repeat (8) @(posedge pclk);
    endtask : set_idle
    task automatic level_pulse(input logic lin, input logic lvl, input int cyc);
        @(posedge pclk);
        if (lin) serial_receive_pin <= lvl;
        else timer_input_pin <= lvl;
        repeat (cyc) @(posedge pclk);
        if (lin) serial_receive_pin <= !lvl;
        else timer_input_pin <= !lvl;
    endtask : level_pulse
endmodule : pin_source_model

// [verification/timer_width_capture_oneshot_monitor.sv]
`timescale 1ns/1ps
module timer_width_capture_oneshot_monitor
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_tick0,
    input wire logic count_tick1,
    input wire logic timer_input_pin,
    input wire logic serial_receive_pin,
    input wire logic [1:0] channel_enable_status,
    input wire logic channel_done_irq,
    input wire logic slave_done_irq,
    input wire logic slave_output_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_trig_wr;
        psel && penable && pwrite && paddr == ADDR_TRIG;
    endsequence
    sequence s_rd_setup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    property p_start_en;
        s_trig_wr ##0 (pwdata[TRIG_START_M] && !pwdata[TRIG_STOP_M])
            |=> channel_enable_status[0];
    endproperty
    property p_stop_m;
        s_trig_wr ##0 (pwdata[TRIG_STOP_M] && !pwdata[TRIG_START_M])
            |=> !channel_enable_status[0];
    endproperty
    property p_stop_s;
        s_trig_wr ##0 (pwdata[TRIG_STOP_S] && !pwdata[TRIG_START_S])
            |=> !channel_enable_status[1];
    endproperty
    property p_trig_zero;
        s_rd_setup(ADDR_TRIG) |=> prdata == 32'h0;
    endproperty
    property p_en_rd;
        s_rd_setup(ADDR_EN)
            |=> prdata == {30'h0, $past(channel_enable_status)};
    endproperty
    property p_stat_rd;
        s_rd_setup(ADDR_STAT) |=> prdata[31:1] == 31'h0;
    endproperty
    // A done pulse without an enabled channel means a stale count ran on
    property p_done_en;
        channel_done_irq |-> $past(channel_enable_status[0]);
    endproperty
    property p_sdone_en;
        slave_done_irq |-> $past(channel_enable_status[1]);
    endproperty
    property p_done_pulse;
        channel_done_irq |=> !channel_done_irq;
    endproperty
    property p_slverr;
        psel && !penable |=> pslverr ==
            ($past(paddr) > ADDR_ISC || $past(paddr[1:0]) != 2'h0);
    endproperty

    a_start_en: assert property (p_start_en)
        else $error("start write left enable low");
    a_stop_m: assert property (p_stop_m)
        else $error("master stop left enable high");
    a_stop_s: assert property (p_stop_s)
        else $error("slave stop left enable high");
    a_trig_zero: assert property (p_trig_zero)
        else $error("trigger register read nonzero");
    a_en_rd: assert property (p_en_rd)
        else $error("enable read differs from status");
    a_stat_rd: assert property (p_stat_rd)
        else $error("status upper bits nonzero");
    a_done_en: assert property (p_done_en)
        else $error("done pulse while disabled");
    a_sdone_en: assert property (p_sdone_en)
        else $error("slave done while disabled");
    a_done_pulse: assert property (p_done_pulse)
        else $error("done pulse longer than one cycle");
    a_slverr: assert property (p_slverr)
        else $error("slave error differs from address map");
endmodule : timer_width_capture_oneshot_monitor

bind timer_width_capture_oneshot timer_width_capture_oneshot_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick0(count_tick0),
    .count_tick1(count_tick1), .timer_input_pin(timer_input_pin),
    .serial_receive_pin(serial_receive_pin),
    .channel_enable_status(channel_enable_status),
    .channel_done_irq(channel_done_irq), .slave_done_irq(slave_done_irq),
    .slave_output_pin(slave_output_pin)
);

// [verification/timer_width_capture_oneshot_test.sv]
`timescale 1ns/1ps
module timer_width_capture_oneshot_test
    import timer_pkg::*;
();
    typedef struct { string nm; logic [31:0] v; } note_type;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, count_tick0 = 0, count_tick1 = 0;
    logic timer_input_pin, serial_receive_pin, slave_output_pin;
    logic channel_done_irq, slave_done_irq;
    logic [1:0] channel_enable_status;
    int failures = 0, total_checks = 0, hi = 0, ph = 0, n = 0;
    note_type q_rd[$], nt;
    int q_pw[$];

    always #50 pclk = ~pclk;
    // Slow tick every other cycle, fast tick every cycle
    always @(posedge pclk) begin
        ph <= ph + 1;
        count_tick0 <= ph[0];
        count_tick1 <= 1'b1;
    end

    timer_width_capture_oneshot u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_tick0(count_tick0),
        .count_tick1(count_tick1), .timer_input_pin(timer_input_pin),
        .serial_receive_pin(serial_receive_pin),
        .channel_enable_status(channel_enable_status),
        .channel_done_irq(channel_done_irq),
        .slave_done_irq(slave_done_irq),
        .slave_output_pin(slave_output_pin));
    pin_source_model u_src (.pclk(pclk), .timer_input_pin(timer_input_pin),
        .serial_receive_pin(serial_receive_pin));

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp=%h got=%h", nm, e, g);
        end
    endtask : chk

    task automatic final_report();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        q_rd.push_back('{nm, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Read data and pulse widths are checked here as they appear
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            nt = q_rd.pop_front();
            chk(nt.nm, nt.v, prdata);
        end
        if (slave_output_pin === 1'b1) hi++;
        else if (hi > 0) begin
            chk("pulse width", q_pw.pop_front(), hi);
            hi = 0;
        end
    end

    task automatic wait_irq();
        do @(posedge pclk); while (channel_done_irq !== 1'b1);
    endtask : wait_irq

    task automatic width(input logic lin, input logic [1:0] cis,
        input logic cks, input int w, input logic st);
        if (st) begin
            apb(1'b1, ADDR_TRIG, 32'h4);
            apb(1'b1, ADDR_MODE, {28'h0, cks, cis, 1'b0});
            u_src.set_idle(lin, !cis[0]);
            apb(1'b1, ADDR_TRIG, 32'h1);
        end
        u_src.level_pulse(lin, cis[0], cks ? w : 2 * w);
        wait_irq();
        rd(ADDR_MDATA, (w - 1) % 65536, "data");
        rd(ADDR_MCNT, w % 65536, "count");
        rd(ADDR_STAT, w > 65536, "overflow");
        rd(ADDR_EN, 32'h1, "enable");
        $display("width test done w=%0d", w);
    endtask : width

    task automatic shot(input logic [31:0] tw, input logic pin_trig);
        int d, s, k;
        d = $urandom_range(20);
        s = 1 + $urandom_range(19);
        apb(1'b1, ADDR_MDATA, d);
        apb(1'b1, ADDR_SDATA, s);
        q_pw.push_back(2 * s);
        k = 0;
        // Input is still routed from the receive pin; its rise triggers
        if (pin_trig) u_src.level_pulse(1'b1, 1'b0, 4);
        else begin
            // Write lands between ticks so the load tick is fixed
            do @(posedge pclk); while (count_tick0 !== 1'b1);
            apb(1'b1, ADDR_TRIG, tw);
            while (slave_output_pin !== 1'b1) begin
                @(posedge pclk);
                if (slave_output_pin !== 1'b1 && count_tick0 === 1'b1) k++;
            end
            // The activating tick is counted as well
            chk("delay", d + 3, k);
        end
        do @(posedge pclk); while (slave_done_irq !== 1'b1);
        rd(ADDR_SCNT, 32'h0, "slave count");
        rd(ADDR_MCNT, 32'h0, "master count");
        rd(ADDR_EN, 32'h3, "pair enable");
        $display("one-shot test done");
    endtask : shot

    initial begin
        void'($urandom(32'h6225));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (q_pw[i]) q_pw.delete();
        for (int a = 0; a <= 'h24; a += 4) rd(a, 32'h0, "reset");
        $display("reset test done");
        n = 3 + $urandom_range(37);
        width(1'b0, CIS_HIGH, 1'b0, n, 1'b1);
        width(1'b0, CIS_HIGH, 1'b0, 3 + $urandom_range(37), 1'b0);
        n = 3 + $urandom_range(37);
        width(1'b0, CIS_LOW, 1'b0, n, 1'b1);
        apb(1'b1, ADDR_TRIG, 32'h4);
        rd(ADDR_EN, 32'h0, "stop enable");
        rd(ADDR_MCNT, n, "stop count");
        rd(ADDR_TRIG, 32'h0, "trigger clear");
        width(1'b0, CIS_HIGH, 1'b1, 65536 + 2 + $urandom_range(18), 1'b1);
        apb(1'b1, ADDR_TRIG, 32'h4);
        rd(ADDR_STAT, 32'h1, "held overflow");
        width(1'b0, CIS_HIGH, 1'b1, 3 + $urandom_range(37), 1'b1);
        apb(1'b1, ADDR_ISC, 32'h2);
        width(1'b1, CIS_LOW, 1'b1, 3 + $urandom_range(37), 1'b1);
        apb(1'b1, ADDR_TRIG, 32'hc);
        apb(1'b1, ADDR_MODE, 32'h21);
        shot(32'h3, 1'b0);
        shot(32'h1, 1'b0);
        apb(1'b1, ADDR_MODE, 32'h23);
        shot(32'h0, 1'b1);
        final_report();
    end

    initial begin
        #9800000;
        failures++;
        final_report();
    end
endmodule : timer_width_capture_oneshot_test

// [verilog/timer_pkg.sv]
package timer_pkg;

    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_TRIG = 8'h04;
    localparam logic [7:0] ADDR_EN = 8'h08;
    localparam logic [7:0] ADDR_MDATA = 8'h0c;
    localparam logic [7:0] ADDR_SDATA = 8'h10;
    localparam logic [7:0] ADDR_MCNT = 8'h14;
    localparam logic [7:0] ADDR_SCNT = 8'h18;
    localparam logic [7:0] ADDR_STAT = 8'h1c;
    localparam logic [7:0] ADDR_ISC = 8'h20;

    // Trigger register bits
    localparam int TRIG_START_M = 0;
    localparam int TRIG_START_S = 1;
    localparam int TRIG_STOP_M = 2;
    localparam int TRIG_STOP_S = 3;

    localparam int OVF_BIT = 0;
    localparam int ISC_LIN_BIT = 1;
    localparam int MODE_W = 7;

    // Mode register, bit 0 at the bottom of the struct
    typedef struct packed {
        logic out_value;
        logic out_en;
        logic out_level;
        logic cks;
        logic [1:0] cis;
        logic oneshot;
    } mode_reg_type;

    localparam logic [MODE_W-1:0] MODE_RST = 7'h00;

    localparam logic [1:0] CIS_FALL = 2'h0;
    localparam logic [1:0] CIS_RISE = 2'h1;
    localparam logic [1:0] CIS_LOW = 2'h2;
    localparam logic [1:0] CIS_HIGH = 2'h3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_COUNT = 3'b100
    } chan_state_type;

endpackage : timer_pkg

// [verilog/timer_width_capture_oneshot.sv]
// Notes on behaviour
// - Width mode: start trigger sets enable and waits for start edge.
// - Start edge clears counter to 0000H, then counts up per count tick.
// - Capture edge copies counter to data register, done pulse same edge.
// - Capture sets overflow bit 0 if wrapped during measurement, else clears.
// - After capture counter holds captured value plus one, waits again.
// - Overflow is one cumulative bit; repeated wraps look the same.
// - Edge select 10B measures low width, 11B measures high width.
// - High width: rise starts, fall captures; low width the reverse.
// - Input is sampled on the selected operating tick.
// - Width = period x (10000H x overflow + captured + 1).
// - Stop trigger clears enable, counter and overflow are held.
// - Start and stop trigger bits self-clear and read as zero.
// - Master loads data on trigger, counts down, done at 0000H.
// - Slave starts on master done, loads, counts down, done at 0000H.
// - Slave pin active one tick after master done, off at 0000H.
// - Delay is master data plus 2 ticks; width is slave data ticks.
// - Software master start also launches a one-shot sequence.
// - Pair is even master channel n and slave channel n+1.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module timer_width_capture_oneshot
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick0,
    input wire logic count_tick1,
    input wire logic timer_input_pin,
    input wire logic serial_receive_pin,
    output logic [1:0] channel_enable_status,
    output logic channel_done_irq,
    output logic slave_done_irq,
    output logic slave_output_pin
);

    mode_reg_type mode_ff;
    logic [CNT_W-1:0] channel_data_reg_ff;
    logic [CNT_W-1:0] slave_data_reg_ff;
    logic [CNT_W-1:0] channel_counter_ff;
    logic [CNT_W-1:0] nxt_channel_counter;
    logic [CNT_W-1:0] slave_counter_ff;
    logic [CNT_W-1:0] nxt_slave_counter;
    logic overflow_flag_ff;
    logic ovf_acc_ff;
    logic nxt_ovf_acc;
    logic lin_input_route_bit_ff;
    logic [1:0] en_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    chan_state_type mstate_ff;
    chan_state_type nxt_mstate;
    chan_state_type sstate_ff;
    chan_state_type nxt_sstate;
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic level_ff;
    logic sample_ff;
    logic mpend_ff;
    logic spend_ff;
    logic active_ff;
    logic nxt_active;
    logic pin_ff;
    logic mdone_ff;
    logic sdone_ff;
    logic capture;
    logic mdone;
    logic sdone;
    logic tick;
    logic raw_in;
    logic wr;
    logic setup;
    logic mapped;
    logic start_m;
    logic start_s;
    logic stop_m;
    logic stop_s;
    logic start_edge;
    logic cap_edge;
    logic trig_edge;
    logic mtrig;
    edge_type edges;

    assign wr = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign channel_enable_status = en_ff;
    assign channel_done_irq = mdone_ff;
    assign slave_done_irq = sdone_ff;
    assign slave_output_pin = pin_ff;

    // Triggers are pulses, never stored, so they self-clear
    assign start_m = wr & (paddr == ADDR_TRIG) & pwdata[TRIG_START_M];
    assign start_s = wr & (paddr == ADDR_TRIG) & pwdata[TRIG_START_S];
    assign stop_m = wr & (paddr == ADDR_TRIG) & pwdata[TRIG_STOP_M];
    assign stop_s = wr & (paddr == ADDR_TRIG) & pwdata[TRIG_STOP_S];

    always_comb begin
        case (paddr)
            ADDR_MODE, ADDR_TRIG, ADDR_EN, ADDR_MDATA, ADDR_SDATA,
            ADDR_MCNT, ADDR_SCNT, ADDR_STAT, ADDR_ISC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Input routing and sampling
    assign raw_in = lin_input_route_bit_ff ? serial_receive_pin
                                           : timer_input_pin;
    assign tick = mode_ff.cks ? count_tick1 : count_tick0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                level_ff <= sync3_ff;
            end
        end
    end

    // Level is only looked at on the operating tick, so a width can be
    // off by one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_ff <= 1'b0;
        end else if (tick) begin
            sample_ff <= level_ff;
        end
    end

    assign edges.rise = tick & level_ff & ~sample_ff;
    assign edges.fall = tick & ~level_ff & sample_ff;

    // Low bit of the edge select picks which level is measured
    assign start_edge = mode_ff.cis[0] ? edges.rise : edges.fall;
    assign cap_edge = mode_ff.cis[0] ? edges.fall : edges.rise;

    always_comb begin
        case (mode_ff.cis)
            CIS_FALL: trig_edge = edges.fall;
            CIS_RISE: trig_edge = edges.rise;
            default: trig_edge = edges.rise | edges.fall;
        endcase
    end

    // Either a pin edge or a software start launches a one-shot
    assign mtrig = trig_edge | start_m;

    // Enable status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 2'h0;
        end else begin
            if (stop_m) begin
                en_ff[0] <= 1'b0;
            end else if (start_m) begin
                en_ff[0] <= 1'b1;
            end
            if (stop_s) begin
                en_ff[1] <= 1'b0;
            end else if (start_s) begin
                en_ff[1] <= 1'b1;
            end
        end
    end

    // Master channel (channel n, even): width capture or delay counter
    always_comb begin
        nxt_mstate = mstate_ff;
        nxt_channel_counter = channel_counter_ff;
        nxt_ovf_acc = ovf_acc_ff;
        capture = 1'b0;
        mdone = 1'b0;
        if (stop_m) begin
            nxt_mstate = ST_IDLE;
        end else begin
            case (mstate_ff)
                ST_IDLE: begin
                    // A first software start is already a one-shot trigger
                    if (start_m && mode_ff.oneshot && tick) begin
                        nxt_channel_counter = channel_data_reg_ff;
                        nxt_mstate = ST_COUNT;
                    end else if (start_m) begin
                        nxt_mstate = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (mode_ff.oneshot) begin
                        if (tick && (mpend_ff || mtrig)) begin
                            nxt_channel_counter = channel_data_reg_ff;
                            nxt_mstate = ST_COUNT;
                        end
                    end else if (start_edge) begin
                        nxt_channel_counter = CNT_ZERO;
                        nxt_ovf_acc = 1'b0;
                        nxt_mstate = ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (!tick) begin
                        nxt_mstate = ST_COUNT;
                    end else if (mode_ff.oneshot) begin
                        if (channel_counter_ff == CNT_ZERO) begin
                            mdone = 1'b1;
                            nxt_mstate = ST_WAIT;
                        end else begin
                            nxt_channel_counter = channel_counter_ff - CNT_ONE;
                        end
                    end else begin
                        // Halts at captured value plus one
                        nxt_channel_counter = channel_counter_ff + CNT_ONE;
                        if (cap_edge) begin
                            capture = 1'b1;
                            nxt_mstate = ST_WAIT;
                        end else if (channel_counter_ff == CNT_FULL) begin
                            nxt_ovf_acc = 1'b1;
                        end
                    end
                end
                default: nxt_mstate = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstate_ff <= ST_IDLE;
            channel_counter_ff <= CNT_ZERO;
            ovf_acc_ff <= 1'b0;
        end else begin
            mstate_ff <= nxt_mstate;
            channel_counter_ff <= nxt_channel_counter;
            ovf_acc_ff <= nxt_ovf_acc;
        end
    end

    // Pending trigger between ticks; only a start arms it, from idle or waiting; pin edges come only on ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mpend_ff <= 1'b0;
        end else if (mstate_ff == ST_COUNT || tick || stop_m) begin
            mpend_ff <= 1'b0;
        end else if (mode_ff.oneshot &&
                     (start_m || (mstate_ff == ST_WAIT && trig_edge))) begin
            mpend_ff <= 1'b1;
        end
    end

    // Captured width and its overflow, valid together with the done pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_ff <= 1'b0;
        end else if (capture) begin
            overflow_flag_ff <= ovf_acc_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdone_ff <= 1'b0;
            sdone_ff <= 1'b0;
        end else begin
            mdone_ff <= capture | mdone;
            sdone_ff <= sdone;
        end
    end

    // Slave channel (n+1): started by master done, one tick later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spend_ff <= 1'b0;
        end else if (sstate_ff != ST_WAIT || stop_s) begin
            spend_ff <= 1'b0;
        end else if (mdone) begin
            spend_ff <= 1'b1;
        end else if (tick) begin
            spend_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_sstate = sstate_ff;
        nxt_slave_counter = slave_counter_ff;
        nxt_active = active_ff;
        sdone = 1'b0;
        if (stop_s) begin
            nxt_sstate = ST_IDLE; // Pin level is held on stop
        end else begin
            case (sstate_ff)
                ST_IDLE: begin
                    if (start_s) begin
                        nxt_sstate = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tick && spend_ff && mode_ff.oneshot) begin
                        nxt_slave_counter = slave_data_reg_ff;
                        if (slave_data_reg_ff == CNT_ZERO) begin
                            sdone = 1'b1;
                        end else begin
                            nxt_active = 1'b1;
                            nxt_sstate = ST_COUNT;
                        end
                    end
                end
                ST_COUNT: begin
                    if (tick) begin
                        nxt_slave_counter = slave_counter_ff - CNT_ONE;
                        if (slave_counter_ff <= CNT_ONE) begin
                            nxt_slave_counter = CNT_ZERO;
                            nxt_active = 1'b0;
                            sdone = 1'b1;
                            nxt_sstate = ST_WAIT;
                        end
                    end
                end
                default: nxt_sstate = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sstate_ff <= ST_IDLE;
            slave_counter_ff <= CNT_ZERO;
            active_ff <= 1'b0;
        end else begin
            sstate_ff <= nxt_sstate;
            slave_counter_ff <= nxt_slave_counter;
            active_ff <= nxt_active;
        end
    end

    // Output stage: level bit inverts the active sense, value bit is the
    // idle level while the timer does not own the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
        end else if (mode_ff.out_en) begin
            pin_ff <= active_ff ^ mode_ff.out_level;
        end else begin
            pin_ff <= mode_ff.out_value;
        end
    end

    // Register writes; a capture in the same cycle wins over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= mode_reg_type'(MODE_RST);
            lin_input_route_bit_ff <= 1'b0;
            slave_data_reg_ff <= CNT_ZERO;
        end else if (wr) begin
            if (paddr == ADDR_MODE) begin
                mode_ff <= mode_reg_type'(pwdata[MODE_W-1:0]);
            end
            if (paddr == ADDR_ISC) begin
                lin_input_route_bit_ff <= pwdata[ISC_LIN_BIT];
            end
            if (paddr == ADDR_SDATA) begin
                slave_data_reg_ff <= pwdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_data_reg_ff <= CNT_ZERO;
        end else if (capture) begin
            channel_data_reg_ff <= channel_counter_ff;
        end else if (wr && paddr == ADDR_MDATA) begin
            channel_data_reg_ff <= pwdata[CNT_W-1:0];
        end
    end

    // Read data is taken in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            pslverr_ff <= ~mapped;
            prdata_ff <= 32'h0000_0000;
            case (paddr)
                ADDR_MODE: prdata_ff[MODE_W-1:0] <= mode_ff;
                ADDR_EN: prdata_ff[1:0] <= en_ff;
                ADDR_MDATA: prdata_ff[CNT_W-1:0] <= channel_data_reg_ff;
                ADDR_SDATA: prdata_ff[CNT_W-1:0] <= slave_data_reg_ff;
                ADDR_MCNT: prdata_ff[CNT_W-1:0] <= channel_counter_ff;
                ADDR_SCNT: prdata_ff[CNT_W-1:0] <= slave_counter_ff;
                ADDR_STAT: prdata_ff[OVF_BIT] <= overflow_flag_ff;
                ADDR_ISC: prdata_ff[ISC_LIN_BIT] <= lin_input_route_bit_ff;
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

endmodule : timer_width_capture_oneshot
